// ---- hdl/ocr_pkg.sv ----
/*
 * Shared constants for the output coding and reference detect block:
 * APB register offsets, field positions, reset values and timing counts.
 * Assumes a 100 MHz REF_CLK and a 32-bit APB master.
 */
// Contract
// [R1] Unipolar coding is straight binary, zero gives zeros
// [R2] Bipolar is offset binary, zero gives MSB only
// [R3] Polarity changes coding and calibration points only
// [R4] Polarity applies to currently selected channel
// [R5] Both burnout currents switch together; zero disables
// [R6] Burnout currents route to selected input pair
// [R7] Flag set when reference low or open
// [R8] Missing reference forces all-ones conversion result
// [R9] Missing reference blocks calibration coefficient update
// [R10] Host checks flag on all-ones or calibration
// [R11] High reference select picks 5 V over 2.5 V
// [R12] Positive full scale gives all ones, both codings
package ocr_pkg;
	localparam int OCR_DATA_W = 24;                 // Result width
	localparam int OCR_CHAN_W = 3;                  // Channel select width
	// Register byte offsets
	localparam logic [7:0] OCR_MODE_OFS   = 8'h00;  // Mode / control
	localparam logic [7:0] OCR_STATUS_OFS = 8'h04;  // Status
	localparam logic [7:0] OCR_DATA_OFS   = 8'h08;  // Conversion result
	localparam logic [7:0] OCR_OFFCAL_OFS = 8'h0c;  // Offset coefficient
	localparam logic [7:0] OCR_GAINCAL_OFS = 8'h10; // Gain coefficient
	// Mode register fields
	localparam int OCR_UNIPOLAR_BIT = 0;            // 1 = unipolar
	localparam int OCR_BURNOUT_BIT  = 1;            // Burnout enable
	localparam int OCR_HIGH_REFERENCE_SELECT_BIT    = 2;            // High reference
	localparam int OCR_CHAN_LSB     = 4;            // Channel field
	localparam int OCR_MODE_LSB     = 8;            // Operating mode
	localparam int OCR_MODE_W       = 2;
	// Status register fields
	localparam int OCR_REFMISS_BIT  = 0;            // Reference missing
	localparam int OCR_READY_BIT    = 1;            // New result
	// Operating modes
	localparam logic [1:0] OCR_OP_IDLE    = 2'h0;
	localparam logic [1:0] OCR_OP_CONVERT = 2'h1;
	localparam logic [1:0] OCR_OP_OFFCAL  = 2'h2;
	localparam logic [1:0] OCR_OP_GAINCAL = 2'h3;
	// Reset values
	localparam logic [31:0] OCR_MODE_RST  = 32'h0000_0000;
	localparam logic [23:0] OCR_GAIN_RST  = 24'h80_0000;
	// Reference detect filter: the comparator must agree this long
	localparam int OCR_REF_FILT_NS = 100;
	localparam int OCR_CLK_NS      = 10;
	localparam int OCR_REF_FILT_CYC =
		(OCR_REF_FILT_NS + OCR_CLK_NS - 1) / OCR_CLK_NS;
endpackage : ocr_pkg

// ---- hdl/ocr_coder.sv ----
/*
 * Result coder: maps a signed modulator/filter sample onto the
 * unipolar or bipolar output word. Assumes the filter delivers a
 * two's complement value scaled to full scale of the selected range.
 */
`timescale 1ns/1ps
module ocr_coder
	import ocr_pkg::*;
#(
	parameter int W = OCR_DATA_W
) (
	input  wire logic         unipolar,    // 1 = straight binary
	input  wire logic [W-1:0] sample,      // Signed filtered value
	output logic      [W-1:0] code         // Coded result word
);
	// Unipolar: negative inputs clamp to zero, positive doubled
	logic         neg;                     // Sample below zero
	logic [W-1:0] uni_code;                // Straight binary form
	logic [W-1:0] bip_code;                // Offset binary form
	assign neg      = sample[W-1];
	assign uni_code = neg ? '0 : {sample[W-2:0], sample[W-2]}; // R1 R12
	// Offset binary is two's complement with the MSB inverted
	assign bip_code = {~sample[W-1], sample[W-2:0]}; // R2 R12
	// Coding choice leaves the sample path untouched
	assign code = unipolar ? uni_code : bip_code; // R3
endmodule : ocr_coder

// ---- hdl/ocr_top.sv ----
/*
 * Output coding, burnout control and reference detect for a sigma-delta
 * converter, with an APB register slave. Assumes the filter supplies
 * signed samples with a strobe, and that the reference comparator and
 * open-circuit detectors deliver levels synchronous to REF_CLK.
 */
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
module ocr_top
	import ocr_pkg::*;
#(
	parameter int W  = OCR_DATA_W,
	parameter int CW = OCR_CHAN_W
) (
	input  wire logic          REF_CLK,        // 100 MHz clock
	input  wire logic          RST_B,          // Async reset, low
	input  wire logic          PSEL,           // APB select
	input  wire logic          PENABLE,        // APB access phase
	input  wire logic          PWRITE,         // APB direction
	input  wire logic [7:0]    PADDR,          // APB byte address
	input  wire logic [31:0]   PWDATA,         // APB write data
	input  wire logic [3:0]    PSTRB,          // APB byte strobes
	output logic               PREADY,         // APB ready
	output logic [31:0]        PRDATA,         // APB read data
	output logic               PSLVERR,        // APB error
	input  wire logic          SAMPLE_VALID,   // Filter result strobe
	input  wire logic [W-1:0]  SAMPLE,         // Signed filter result
	input  wire logic          CAL_DONE,       // Calibration finished
	input  wire logic [W-1:0]  CAL_VALUE,      // New coefficient
	input  wire logic          REF_LOW,        // Ref below 0.3 V
	input  wire logic          REF_POS_OPEN,   // Positive ref open
	input  wire logic          REF_NEG_OPEN,   // Negative ref open
	output logic               BURNOUT_SOURCE, // Source current on
	output logic               BURNOUT_SINK,   // Sink current on
	output logic [CW-1:0]      BURNOUT_CHAN,   // Pair for currents
	output logic [CW-1:0]      CHAN_SELECT,    // Converted channel
	output logic               HIGH_REF_SEL,   // 1 = 5 V reference
	output logic               UNIPOLAR,       // Coding/cal points
	output logic [1:0]         OP_MODE         // Operating mode
);
	// Operating state machine, one-hot
	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0001,
		ST_CONVERT = 4'b0010,
		ST_OFFCAL  = 4'b0100,
		ST_GAINCAL = 4'b1000
	} ocr_state_type;

	logic [31:0]   mode_reg;          // Software control word
	logic [W-1:0]  data_reg;          // Conversion result
	logic [W-1:0]  offcal_reg;        // Offset coefficient
	logic [W-1:0]  gaincal_reg;       // Gain coefficient
	logic          ready;             // New result flag
	logic          ref_missing;       // Reference missing flag
	logic [7:0]    ref_cnt;           // Bad-reference filter
	logic          cal_fault;         // Ref lost during calibration
	ocr_state_type state;             // Current operation
	ocr_state_type next_state;        // Decoded operation
	logic [W-1:0]  coded;             // Coder output

	// Decoded bus strobes
	wire logic     wr_en = PSEL & PENABLE & PWRITE;
	wire logic     rd_en = PSEL & PENABLE & ~PWRITE;
	wire logic     addr_ok;
	wire logic     ref_bad = REF_LOW | REF_POS_OPEN | REF_NEG_OPEN;
	wire logic     conv_upd = SAMPLE_VALID & (state == ST_CONVERT);
	wire logic     cal_upd = CAL_DONE & ~cal_fault & ~ref_missing;

	// Address decode used for the error only; the read mux decodes PADDR itself
	function automatic logic ocr_mapped(input logic [7:0] a);
		ocr_mapped = (a == OCR_MODE_OFS) || (a == OCR_STATUS_OFS) ||
			(a == OCR_DATA_OFS) || (a == OCR_OFFCAL_OFS) ||
			(a == OCR_GAINCAL_OFS);
	endfunction : ocr_mapped

	assign addr_ok = ocr_mapped(PADDR);

	// Zero wait state slave; unmapped or unaligned gives an error
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~addr_ok;

	// Software fields driving the analog side
	assign UNIPOLAR     = mode_reg[OCR_UNIPOLAR_BIT];
	assign HIGH_REF_SEL = mode_reg[OCR_HIGH_REFERENCE_SELECT_BIT]; // R11
	assign CHAN_SELECT  = mode_reg[OCR_CHAN_LSB +: CW]; // R4
	// Both currents come from one bit, so they can never differ
	assign BURNOUT_SOURCE = mode_reg[OCR_BURNOUT_BIT]; // R5
	assign BURNOUT_SINK   = mode_reg[OCR_BURNOUT_BIT]; // R5
	assign BURNOUT_CHAN   = mode_reg[OCR_CHAN_LSB +: CW]; // R6
	assign OP_MODE        = mode_reg[OCR_MODE_LSB +: OCR_MODE_W];

	// Coder follows the channel's polarity setting
	ocr_coder #(
		.W(W)
	) u_coder (
		.unipolar (UNIPOLAR), // R4
		.sample   (SAMPLE),
		.code     (coded)
	);

	// Mode decode into operating state
	always_comb begin
		case (OP_MODE)
			OCR_OP_CONVERT: next_state = ST_CONVERT;
			OCR_OP_OFFCAL:  next_state = ST_OFFCAL;
			OCR_OP_GAINCAL: next_state = ST_GAINCAL;
			default:        next_state = ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Mode register with byte strobes
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			mode_reg <= OCR_MODE_RST;
		end else if (wr_en && PADDR == OCR_MODE_OFS) begin
			for (int i = 0; i < 4; i++) begin
				if (PSTRB[i]) begin
					mode_reg[8*i +: 8] <= PWDATA[8*i +: 8];
				end
			end
		end
	end

	// Reference filter: glitches shorter than the filter are ignored
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ref_cnt <= '0;
		end else if (!ref_bad) begin
			ref_cnt <= '0;
		end else if (ref_cnt < 8'(OCR_REF_FILT_CYC)) begin
			ref_cnt <= ref_cnt + 8'h01;
		end
	end

	// Flag follows the filtered detector level
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ref_missing <= 1'b0;
		end else if (ref_bad && ref_cnt >= 8'(OCR_REF_FILT_CYC - 1)) begin
			ref_missing <= 1'b1; // R7
		end else if (!ref_bad) begin
			ref_missing <= 1'b0;
		end
	end

	// Any loss during a calibration spoils that calibration
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			cal_fault <= 1'b0;
		end else if (state != ST_OFFCAL && state != ST_GAINCAL) begin
			cal_fault <= 1'b0;
		end else if (ref_missing) begin
			cal_fault <= 1'b1; // R9
		end
	end

	// Result register; all ones marks a missing reference
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			data_reg <= '0;
		end else if (conv_upd) begin
			data_reg <= ref_missing ? '1 : coded; // R8
		end
	end

	// Ready flag: new result sets, data read clears; set wins
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ready <= 1'b0;
		end else if (conv_upd) begin
			ready <= 1'b1;
		end else if (rd_en && PADDR == OCR_DATA_OFS) begin
			ready <= 1'b0;
		end
	end

	// Coefficients load only from a clean calibration
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			offcal_reg  <= '0;
			gaincal_reg <= OCR_GAIN_RST;
		end else if (cal_upd && state == ST_OFFCAL) begin
			offcal_reg <= CAL_VALUE; // R9
		end else if (cal_upd && state == ST_GAINCAL) begin
			gaincal_reg <= CAL_VALUE; // R9
		end
	end

	// Read mux; unused bits read as zero
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (PADDR)
			OCR_MODE_OFS:    rd_mux = mode_reg;
			OCR_STATUS_OFS: begin
				rd_mux[OCR_REFMISS_BIT] = ref_missing;
				rd_mux[OCR_READY_BIT]   = ready;
			end
			OCR_DATA_OFS:    rd_mux[W-1:0] = data_reg;
			OCR_OFFCAL_OFS:  rd_mux[W-1:0] = offcal_reg;
			OCR_GAINCAL_OFS: rd_mux[W-1:0] = gaincal_reg;
			default:         rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data registered at the edge that ends the setup phase
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			PRDATA <= 32'h0000_0000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			PRDATA <= rd_mux;
		end
	end

	// Checks: each watches what this block drives, not the stimulus
	// Ten bad samples in a row, so the filter has run out
	sequence s_bad_held;
		ref_bad [*8] ##1 ref_bad [*2];
	endsequence

	// A mode register write that reaches the low control byte
	sequence s_mode_low_write;
		wr_en && PADDR == OCR_MODE_OFS && PSTRB[0];
	endsequence

	// Offset calibration already spoiled by a lost reference
	sequence s_offcal_spoiled;
		(state == ST_OFFCAL) && (cal_fault || ref_missing);
	endsequence

	// Gain calibration already spoiled by a lost reference
	sequence s_gaincal_spoiled;
		(state == ST_GAINCAL) && (cal_fault || ref_missing);
	endsequence

	// Flag stands the edge after the filter has counted out
	chk_ref_flag_set: assert property ( // R7
		@(posedge REF_CLK) disable iff (!RST_B)
		s_bad_held |=> ref_missing)
		else $error("reference flag not raised");

	// A healthy reference drops the flag on the next edge
	chk_ref_flag_clear: assert property ( // R7
		@(posedge REF_CLK) disable iff (!RST_B)
		!ref_bad |=> !ref_missing)
		else $error("reference flag held after recovery");

	// Missing reference overrides whatever the coder produced
	chk_allones_result: assert property ( // R8
		@(posedge REF_CLK) disable iff (!RST_B)
		conv_upd && ref_missing |=> data_reg == '1)
		else $error("result not all ones with reference missing");

	// Spoiled offset calibration leaves its coefficient alone
	chk_cal_blocked: assert property ( // R9
		@(posedge REF_CLK) disable iff (!RST_B)
		s_offcal_spoiled |=> $stable(offcal_reg))
		else $error("offset coefficient updated without reference");

	// Same guard on the gain side
	chk_gaincal_blocked: assert property ( // R9
		@(posedge REF_CLK) disable iff (!RST_B)
		s_gaincal_spoiled |=> $stable(gaincal_reg))
		else $error("gain coefficient updated without reference");

	// A clean offset calibration does load, so a stuck offset register is caught
	chk_offcal_loads: assert property ( // R9
		@(posedge REF_CLK) disable iff (!RST_B)
		cal_upd && state == ST_OFFCAL
		|=> offcal_reg == $past(CAL_VALUE))
		else $error("offset coefficient not loaded");

	// Source and sink always agree
	chk_burnout_pair: assert property ( // R5
		@(posedge REF_CLK) disable iff (!RST_B)
		BURNOUT_SOURCE == BURNOUT_SINK)
		else $error("burnout currents differ");

	// Writing zero to the enable turns both currents off
	chk_burnout_off: assert property ( // R5
		@(posedge REF_CLK) disable iff (!RST_B)
		s_mode_low_write ##0 !PWDATA[OCR_BURNOUT_BIT]
		|=> !BURNOUT_SOURCE && !BURNOUT_SINK)
		else $error("burnout not turned off");

	// Bipolar zero is the mid code
	chk_bipolar_zero: assert property ( // R2
		@(posedge REF_CLK) disable iff (!RST_B)
		conv_upd && !ref_missing && !UNIPOLAR && SAMPLE == '0
		|=> data_reg == {1'b1, {(W-1){1'b0}}})
		else $error("bipolar zero not mid code");

	// Bipolar negative full scale is all zeros
	chk_bipolar_negfs: assert property ( // R2
		@(posedge REF_CLK) disable iff (!RST_B)
		conv_upd && !ref_missing && !UNIPOLAR &&
		SAMPLE == {1'b1, {(W-1){1'b0}}} |=> data_reg == '0)
		else $error("bipolar negative full scale not zero code");

	// Unipolar zero is all zeros
	chk_unipolar_zero: assert property ( // R1
		@(posedge REF_CLK) disable iff (!RST_B)
		conv_upd && !ref_missing && UNIPOLAR && SAMPLE == '0
		|=> data_reg == '0)
		else $error("unipolar zero not zero code");

	// Straight binary has no code below zero, so it clamps
	chk_unipolar_neg: assert property ( // R1
		@(posedge REF_CLK) disable iff (!RST_B)
		conv_upd && !ref_missing && UNIPOLAR && SAMPLE[W-1]
		|=> data_reg == '0)
		else $error("unipolar negative input not clamped");

	// Positive full scale is all ones in either coding
	chk_fullscale_ones: assert property ( // R12
		@(posedge REF_CLK) disable iff (!RST_B)
		conv_upd && SAMPLE == {1'b0, {(W-1){1'b1}}}
		|=> data_reg == '1)
		else $error("full scale not all ones");

	// Currents follow the converted pair
	chk_route_chan: assert property ( // R6
		@(posedge REF_CLK) disable iff (!RST_B)
		BURNOUT_CHAN == CHAN_SELECT)
		else $error("burnout routed to wrong pair");

	// Channel field reaches the converter one edge after the write
	chk_chan_applied: assert property ( // R4
		@(posedge REF_CLK) disable iff (!RST_B)
		s_mode_low_write
		|=> CHAN_SELECT == $past(PWDATA[OCR_CHAN_LSB +: CW]))
		else $error("channel select not applied");

	// Reference range bit reaches the analog side likewise
	chk_high_reference_select_out: assert property ( // R11
		@(posedge REF_CLK) disable iff (!RST_B)
		s_mode_low_write
		|=> HIGH_REF_SEL == $past(PWDATA[OCR_HIGH_REFERENCE_SELECT_BIT]))
		else $error("high reference select not applied");
endmodule : ocr_top

// ---- verif/ocr_far_end.sv ----
/*
 * Far-end model: transducer results, calibration results and the
 * reference health levels seen by the detector.
 * Assumes the bench calls its tasks one at a time on REF_CLK.
 */
`timescale 1ns/1ps
module ocr_far_end (
	input  wire logic   clk,       // Converter clock
	output logic        s_valid,   // Result strobe
	output logic [23:0] s_data,    // Signed filter result
	output logic        c_done,    // Coefficient strobe
	output logic [23:0] c_data,    // New coefficient
	output logic [2:0]  ref_bad    // Low, positive open, negative open
);
	// Quiet and healthy at time zero
	initial begin
		s_valid = 1'b0;
		c_done  = 1'b0;
		s_data  = 24'h0;
		c_data  = 24'h0;
		ref_bad = 3'h0;
	end

	// One-cycle strobe; afterwards the bus shows the inverse
	// so a stale value can never pass for a fresh one
	task send(input logic [23:0] v, input logic cal);
		@(posedge clk);
		s_valid <= !cal;
		c_done  <= cal;
		s_data  <= v;
		c_data  <= v;
		@(posedge clk);
		s_valid <= 1'b0;
		c_done  <= 1'b0;
		s_data  <= ~v;
		c_data  <= ~v;
	endtask : send

	// Reference condition, held until changed
	task set_ref(input logic [2:0] b);
		@(posedge clk);
		ref_bad <= b;
	endtask : set_ref
endmodule : ocr_far_end

// ---- verif/tb_adc_output_coding_refdetect.sv ----
/*
 * Self-checking bench: APB master, far-end model, read scoreboard.
 * Assumes zero-wait APB slave and a 10-cycle reference filter.
 */
`timescale 1ns/1ps
module tb_adc_output_coding_refdetect import ocr_pkg::*;;
	logic        clk, rst_b, psel, penable, pwrite;
	logic [7:0]  paddr, a;        // Bus address, scratch address
	logic [31:0] pwdata, prdata;  // Bus data
	logic [31:0] seed, r;         // Random state and draw
	logic [3:0]  pstrb;           // Byte strobes
	logic        pready, pslverr, s_valid, c_done;
	logic [23:0] s_data, c_data, v;
	logic [2:0]  ref_bad, bo_ch, ch;
	logic        bo_src, bo_snk, high_reference_select, unip;
	logic [1:0]  op;
	logic [32:0] exp_q [$];       // Expected {error, read data}
	logic [23:0] pts [4] = '{24'h0, 24'h7fffff, 24'h800000, 24'h400000};
	int          fails, n_compared, k, u;

	ocr_top ocr_top_i (.REF_CLK(clk), .RST_B(rst_b), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PSTRB(pstrb), .PREADY(pready), .PRDATA(prdata),
		.PSLVERR(pslverr), .SAMPLE_VALID(s_valid), .SAMPLE(s_data),
		.CAL_DONE(c_done), .CAL_VALUE(c_data), .REF_LOW(ref_bad[0]),
		.REF_POS_OPEN(ref_bad[1]), .REF_NEG_OPEN(ref_bad[2]),
		.BURNOUT_SOURCE(bo_src), .BURNOUT_SINK(bo_snk),
		.BURNOUT_CHAN(bo_ch), .CHAN_SELECT(ch), .HIGH_REF_SEL(high_reference_select),
		.UNIPOLAR(unip), .OP_MODE(op));
	ocr_far_end ocr_far_end_i (.clk(clk), .s_valid(s_valid),
		.s_data(s_data), .c_done(c_done), .c_data(c_data),
		.ref_bad(ref_bad));

	// Free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Fixed-seed xorshift draws
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// Expected result word for either coding
	function logic [23:0] code(input logic uni, input logic [23:0] s);
		if (uni)
			return s[23] ? 24'h0 : {s[22:0], s[22]};
		return s ^ 24'h800000;
	endfunction : code

	task close_out();
		if (fails == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out

	task chk(input logic [32:0] got, input logic [32:0] want);
		n_compared++;
		if (got !== want) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask : chk

	// One APB transfer; reads leave a note for the monitor
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
		input logic [32:0] e);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= ad;
		pwdata  <= d;
		if (!w)
			exp_q.push_back(e);
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			close_out();
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] ad, input logic [31:0] d);
		apb(1'b1, ad, d, 33'h0);
	endtask : wr

	task rd(input logic [7:0] ad, input logic [31:0] e);
		apb(1'b0, ad, 32'h0, {1'b0, e});
	endtask : rd

	// Mode write, then the control pins once settled
	task mode(input logic [31:0] m);
		wr(OCR_MODE_OFS, m);
		#1;
		chk({unip, high_reference_select, bo_ch, ch, op},
			{m[0], m[2], m[6:4], m[6:4], m[9:8]});
		chk({bo_src, bo_snk}, {m[1], m[1]});
	endtask : mode

	// Completed reads are matched against the oldest note
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite)
			chk({pslverr, prdata}, exp_q.pop_front());
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		close_out();
	end

	// Main sequence
	initial begin
		{rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hf;
		seed = 32'h8a08d503;
		fails = 0;
		n_compared = 0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		// Reset values, read-only status, unmapped address
		rd(OCR_MODE_OFS, OCR_MODE_RST);
		rd(OCR_GAINCAL_OFS, {8'h0, OCR_GAIN_RST});
		wr(OCR_STATUS_OFS, 32'h3);
		rd(OCR_STATUS_OFS, 32'h0);
		apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0});
		// Random control words, then burnout off
		for (k = 0; k < 8; k++)
			mode(xs() & 32'h0000_0377);
		mode(32'h0);
		// Strobes: only the operating mode byte lands
		pstrb <= 4'h2;
		wr(OCR_MODE_OFS, 32'h0000_03ff);
		rd(OCR_MODE_OFS, 32'h0000_0300);
		pstrb <= 4'hf;
		mode(32'h0);
		// Coding points in both polarities, random channel
		for (u = 0; u < 2; u++) begin
			for (k = 0; k < 5; k++) begin
				r = xs();
				v = (k < 4) ? pts[k] : r[23:0];
				mode({22'h0, OCR_OP_CONVERT, 1'b0, r[6:4], 1'b0, r[2:1],
					u[0]});
				ocr_far_end_i.send(v, 1'b0);
				rd(OCR_STATUS_OFS, 32'h2);
				rd(OCR_DATA_OFS, {8'h0, code(u[0], v)});
				rd(OCR_STATUS_OFS, 32'h0);
			end
		end
		// Each missing-reference cause forces all ones
		for (k = 0; k < 3; k++) begin
			ocr_far_end_i.set_ref(3'b001 << k);
			repeat (12) @(posedge clk);
			rd(OCR_STATUS_OFS, 32'h1);
			r = xs();
			ocr_far_end_i.send(r[23:0], 1'b0);
			rd(OCR_DATA_OFS, 32'h00ff_ffff);
			ocr_far_end_i.set_ref(3'b000);
			repeat (3) @(posedge clk);
			rd(OCR_STATUS_OFS, 32'h0);
		end
		// Brief dropout below the filter length is ignored
		ocr_far_end_i.set_ref(3'b001);
		repeat (6) @(posedge clk);
		ocr_far_end_i.set_ref(3'b000);
		rd(OCR_STATUS_OFS, 32'h0);
		// Calibration: blocked by a dropout, then accepted
		for (k = 2; k < 4; k++) begin
			a = (k == 2) ? OCR_OFFCAL_OFS : OCR_GAINCAL_OFS;
			mode({22'h0, k[1:0], 8'h0});
			ocr_far_end_i.set_ref(3'b010);
			repeat (12) @(posedge clk);
			ocr_far_end_i.set_ref(3'b000);
			repeat (3) @(posedge clk);
			r = xs();
			ocr_far_end_i.send(r[23:0], 1'b1);
			rd(a, (k == 2) ? 32'h0 : {8'h0, OCR_GAIN_RST});
			rd(OCR_STATUS_OFS, 32'h0);
			mode(32'h0);
			mode({22'h0, k[1:0], 8'h0});
			r = xs();
			v = r[23:0];
			ocr_far_end_i.send(v, 1'b1);
			rd(a, {8'h0, v});
		end
		close_out();
	end
endmodule : tb_adc_output_coding_refdetect
